// ===== rtl/erc_pkg.sv
// Constants and types for the error record enable control block
package erc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] ERC_CTL_BASE    = 12'h008;
  localparam logic [11:0] ERC_REC_STRIDE  = 12'h040;
  localparam int          ERC_NUM_REC     = 4;
  localparam int          ERC_SEL_W       = 2;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ERC_ED_BIT    = 0;
  localparam int ERC_IMPL1_BIT = 1;
  localparam int ERC_RUI_BIT   = 2;
  localparam int ERC_RFI_BIT   = 3;
  localparam int ERC_RUE_BIT   = 4;
  localparam int ERC_WUI_BIT   = 5;
  localparam int ERC_WFI_BIT   = 6;
  localparam int ERC_WUE_BIT   = 7;
  localparam int ERC_READ_CORRECTED_FAULT_IRQ_EN_BIT  = 8;
  localparam int ERC_WRITE_CORRECTED_FAULT_IRQ_EN_BIT  = 9;
  localparam int ERC_READ_DEFERRED_RECOVERY_IRQ_EN_BIT  = 10;
  localparam int ERC_WRITE_DEFERRED_RECOVERY_IRQ_EN_BIT  = 11;

  // ---------------------------------------------------------------
  // Feature field encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ERC_FEAT_NONE     = 2'h0,
    ERC_FEAT_ALWAYS   = 2'h1,
    ERC_FEAT_COMBINED = 2'h2,
    ERC_FEAT_SPLIT    = 2'h3
  } erc_feat_type;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [11:0] ERC_CTL_RESET   = 12'h000;
  localparam logic [31:0] ERC_IMPL_HI_RST = 32'h0000_0000;

  // Byte address decode of a memory-mapped control location
  function automatic logic erc_is_ctl(input logic [11:0] addr, input int idx);
    return addr == 12'(ERC_CTL_BASE + 12'(idx) * ERC_REC_STRIDE);
  endfunction

endpackage

// ===== rtl/erc_ctrl.sv
// Error record enable control register with enable gating of error events
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ps

module erc_ctrl #(
  parameter int                    FIRST_REC   = 0,
  parameter erc_pkg::erc_feat_type FEAT_DUI    = erc_pkg::ERC_FEAT_SPLIT,
  parameter erc_pkg::erc_feat_type FEAT_CFI    = erc_pkg::ERC_FEAT_COMBINED,
  parameter erc_pkg::erc_feat_type FEAT_UE     = erc_pkg::ERC_FEAT_SPLIT,
  parameter erc_pkg::erc_feat_type FEAT_FI     = erc_pkg::ERC_FEAT_COMBINED,
  parameter erc_pkg::erc_feat_type FEAT_UI     = erc_pkg::ERC_FEAT_SPLIT,
  parameter erc_pkg::erc_feat_type FEAT_ED     = erc_pkg::ERC_FEAT_COMBINED,
  parameter logic                  HAS_CE_CNT  = 1'b1,
  parameter logic                  ED_COLD_RST = 1'b0
) (
  input  wire logic                          CLK,
  input  wire logic                          RST,
  input  wire logic                          CE,
  // Memory-mapped access
  input  wire logic                          MM_WR,
  input  wire logic                          MM_RD,
  input  wire logic [11:0]                   MM_ADDR,
  input  wire logic [63:0]                   MM_WDATA,
  output logic      [63:0]                   MM_RDATA,
  // System register windows
  input  wire logic [erc_pkg::ERC_SEL_W-1:0] SEL_IDX,
  input  wire logic                          SR_WR_LO,
  input  wire logic                          SR_WR_HI,
  input  wire logic                          SR_WR_FULL,
  input  wire logic [63:0]                   SR_WDATA,
  output logic      [63:0]                   SR_RDATA,
  // Error events from the detection logic
  input  wire logic                          EV_IS_WRITE,
  input  wire logic                          EV_DEFERRED,
  input  wire logic                          EV_UNCORR,
  input  wire logic                          EV_CORR,
  input  wire logic                          EV_CNT_OVF,
  output logic                               RECOVERY_IRQ,
  output logic                               FAULT_IRQ,
  output logic                               EXT_ABORT,
  output logic                               REPORT_EN,
  output logic                               LOG_EN
);
  import erc_pkg::*;

  // ---------------------------------------------------------------
  // Implemented bit mask
  // ---------------------------------------------------------------
  function automatic logic [11:0] ctl_mask();
    logic [11:0] m;
    m = 12'h000;
    m[ERC_ED_BIT]   = (FEAT_ED  == ERC_FEAT_COMBINED);
    m[ERC_READ_DEFERRED_RECOVERY_IRQ_EN_BIT] = (FEAT_DUI == ERC_FEAT_COMBINED) || (FEAT_DUI == ERC_FEAT_SPLIT);
    m[ERC_WRITE_DEFERRED_RECOVERY_IRQ_EN_BIT] = (FEAT_DUI == ERC_FEAT_SPLIT);
    m[ERC_READ_CORRECTED_FAULT_IRQ_EN_BIT] = (FEAT_CFI == ERC_FEAT_COMBINED) || (FEAT_CFI == ERC_FEAT_SPLIT);
    m[ERC_WRITE_CORRECTED_FAULT_IRQ_EN_BIT] = (FEAT_CFI == ERC_FEAT_SPLIT);
    m[ERC_RUE_BIT]  = (FEAT_UE  == ERC_FEAT_COMBINED) || (FEAT_UE  == ERC_FEAT_SPLIT);
    m[ERC_WUE_BIT]  = (FEAT_UE  == ERC_FEAT_SPLIT);
    m[ERC_RFI_BIT]  = (FEAT_FI  == ERC_FEAT_COMBINED) || (FEAT_FI  == ERC_FEAT_SPLIT);
    m[ERC_WFI_BIT]  = (FEAT_FI  == ERC_FEAT_SPLIT);
    m[ERC_RUI_BIT]  = (FEAT_UI  == ERC_FEAT_COMBINED) || (FEAT_UI  == ERC_FEAT_SPLIT);
    m[ERC_WUI_BIT]  = (FEAT_UI  == ERC_FEAT_SPLIT);
    return m;
  endfunction

  // Effective enable of one control for the direction of the event
  function automatic logic ctl_en(input erc_feat_type f, input logic [11:0] c,
                                  input int rb, input int wb, input logic is_wr);
    case (f)
      ERC_FEAT_ALWAYS:   return 1'b1;
      ERC_FEAT_COMBINED: return c[rb];
      ERC_FEAT_SPLIT:    return is_wr ? c[wb] : c[rb];
      default:           return 1'b0;
    endcase
  endfunction

  localparam logic [11:0] CTL_MASK = ctl_mask();

  logic [11:0] ctl_reg;
  logic [11:0] ctl_next;
  logic [31:0] impl_hi_reg;
  logic        impl1_reg;
  logic        ed_reg;

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  logic mm_hit;
  logic sr_hit;
  logic wr_lo;
  logic wr_hi;
  logic [63:0] wdata;

  always_comb begin
    mm_hit = erc_is_ctl(MM_ADDR, FIRST_REC);
    sr_hit = (int'(SEL_IDX) == FIRST_REC);
    wr_lo  = (MM_WR && mm_hit) || (sr_hit && (SR_WR_LO || SR_WR_FULL));
    wr_hi  = (MM_WR && mm_hit) || (sr_hit && (SR_WR_HI || SR_WR_FULL));
    wdata  = (MM_WR && mm_hit) ? MM_WDATA : SR_WDATA;
    if (SR_WR_HI && !SR_WR_FULL) begin
      wdata[63:32] = SR_WDATA[31:0];
    end
    ctl_next = wdata[11:0] & CTL_MASK;
  end

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctl_reg <= ERC_CTL_RESET;
    end else if (CE && wr_lo) begin
      ctl_reg <= ctl_next;
    end
  end

  // Reporting enable is reset only by cold reset, modelled by RST, and is written when FEAT_ED is combined
  always_ff @(posedge CLK) begin
    if (RST) begin
      ed_reg <= ED_COLD_RST;
    end else if (CE && wr_lo && (FEAT_ED == ERC_FEAT_COMBINED)) begin
      ed_reg <= wdata[ERC_ED_BIT];
    end
  end

  // Implementation controls are plain storage here
  always_ff @(posedge CLK) begin
    if (RST) begin
      impl_hi_reg <= ERC_IMPL_HI_RST;
      impl1_reg   <= 1'b0;
    end else if (CE) begin
      if (wr_hi) begin
        impl_hi_reg <= wdata[63:32];
      end
      if (wr_lo) begin
        impl1_reg <= wdata[ERC_IMPL1_BIT];
      end
    end
  end

  logic [63:0] ctl_view;
  always_comb begin
    ctl_view = {impl_hi_reg, 20'h00000, ctl_reg};
    ctl_view[ERC_IMPL1_BIT] = impl1_reg;
    ctl_view[ERC_ED_BIT]    = (FEAT_ED == ERC_FEAT_COMBINED) ? ed_reg : 1'b0;
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      MM_RDATA <= 64'h0;
      SR_RDATA <= 64'h0;
    end else if (CE) begin
      if (MM_RD) begin
        MM_RDATA <= mm_hit ? ctl_view : 64'h0;
      end
      if (!sr_hit) begin
        SR_RDATA <= 64'h0;
      end else if (SR_WR_HI && !SR_WR_FULL) begin
        SR_RDATA <= {32'h0, ctl_view[63:32]};
      end else begin
        SR_RDATA <= ctl_view;
      end
    end
  end

  // ---------------------------------------------------------------
  // Event gating
  // ---------------------------------------------------------------
  logic rep_on;
  logic en_dui;
  logic en_cfi;
  logic en_ue;
  logic en_fi;
  logic en_ui;
  logic ce_event;
  logic rec_d;
  logic flt_d;
  logic abt_d;

  always_comb begin
    rep_on = (FEAT_ED == ERC_FEAT_ALWAYS) || ed_reg;
    en_dui = ctl_en(FEAT_DUI, ctl_reg, ERC_READ_DEFERRED_RECOVERY_IRQ_EN_BIT, ERC_WRITE_DEFERRED_RECOVERY_IRQ_EN_BIT, EV_IS_WRITE);
    en_cfi = ctl_en(FEAT_CFI, ctl_reg, ERC_READ_CORRECTED_FAULT_IRQ_EN_BIT, ERC_WRITE_CORRECTED_FAULT_IRQ_EN_BIT, EV_IS_WRITE);
    en_ue  = ctl_en(FEAT_UE,  ctl_reg, ERC_RUE_BIT,  ERC_WUE_BIT,  EV_IS_WRITE);
    en_fi  = ctl_en(FEAT_FI,  ctl_reg, ERC_RFI_BIT,  ERC_WFI_BIT,  EV_IS_WRITE);
    en_ui  = ctl_en(FEAT_UI,  ctl_reg, ERC_RUI_BIT,  ERC_WUI_BIT,  EV_IS_WRITE);
    ce_event = HAS_CE_CNT ? EV_CNT_OVF : EV_CORR;
    // Priority of the record syndrome is deliberately not an input: drops never mask
    rec_d = rep_on && ((en_dui && EV_DEFERRED) || (en_ui && EV_UNCORR));
    flt_d = rep_on && ((en_fi && (EV_DEFERRED || EV_UNCORR))
          || (((FEAT_CFI == ERC_FEAT_NONE) ? en_fi : en_cfi) && ce_event));
    abt_d = rep_on && en_ue && EV_UNCORR;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      RECOVERY_IRQ <= 1'b0;
      FAULT_IRQ    <= 1'b0;
      EXT_ABORT    <= 1'b0;
    end else if (CE) begin
      RECOVERY_IRQ <= rec_d;
      FAULT_IRQ    <= flt_d;
      EXT_ABORT    <= abt_d;
    end
  end

  // Reporting and logging enables both follow rep_on, registered one cycle later
  always_ff @(posedge CLK) begin
    if (RST) begin
      REPORT_EN <= 1'b0;
      LOG_EN    <= 1'b0;
    end else if (CE) begin
      REPORT_EN <= rep_on;
      LOG_EN    <= rep_on;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_dui_recovery: assert property (@(posedge CLK) disable iff (RST)
    CE && rep_on && en_dui && EV_DEFERRED |=> RECOVERY_IRQ)
    else $error("deferred recovery pulse missing");
  a_ui_recovery: assert property (@(posedge CLK) disable iff (RST)
    CE && rep_on && en_ui && EV_UNCORR |=> RECOVERY_IRQ)
    else $error("uncorrected recovery pulse missing");
  a_abort_gate: assert property (@(posedge CLK) disable iff (RST)
    CE |=> EXT_ABORT == $past(rep_on && en_ue && EV_UNCORR))
    else $error("abort response mismatch");
  a_fault_du: assert property (@(posedge CLK) disable iff (RST)
    CE && rep_on && en_fi && (EV_DEFERRED || EV_UNCORR) |=> FAULT_IRQ)
    else $error("fault pulse missing");
  a_report_off: assert property (@(posedge CLK) disable iff (RST)
    CE && !rep_on |=> !RECOVERY_IRQ && !FAULT_IRQ && !EXT_ABORT)
    else $error("event signalled while reporting off");
  a_high_zero: assert property (@(posedge CLK) disable iff (RST)
    ctl_view[31:12] == 20'h0 && (ctl_reg & ~CTL_MASK) == 12'h0)
    else $error("reserved control bits set");
  a_other_rec: assert property (@(posedge CLK) disable iff (RST)
    CE && MM_RD && !mm_hit |=> MM_RDATA == 64'h0)
    else $error("non-first record read nonzero");
  a_write_take: assert property (@(posedge CLK) disable iff (RST)
    CE && wr_lo |=> ctl_reg == $past(ctl_next))
    else $error("control write not taken");
  a_irq_pulse: assert property (@(posedge CLK) disable iff (RST)
    CE && !rec_d |=> !RECOVERY_IRQ)
    else $error("recovery pulse without cause");
  a_ce_fault: assert property (@(posedge CLK) disable iff (RST)
    CE && rep_on && en_cfi && ce_event && FEAT_CFI != ERC_FEAT_NONE |=> FAULT_IRQ)
    else $error("corrected fault pulse missing");

  // ---------------------------------------------------------------
  // Direction, window and freeze checks
  // ---------------------------------------------------------------
  // Pulse and level outputs must follow last cycle's gated causes exactly
  a_fault_pulse: assert property (@(posedge CLK) disable iff (RST)
    CE && !flt_d |=> !FAULT_IRQ)
    else $error("fault pulse without cause");
  a_abort_pulse: assert property (@(posedge CLK) disable iff (RST)
    CE && !abt_d |=> !EXT_ABORT)
    else $error("abort pulse without cause");
  a_report_follow: assert property (@(posedge CLK) disable iff (RST)
    CE |=> REPORT_EN == $past(rep_on))
    else $error("report enable level mismatch");
  a_log_follow: assert property (@(posedge CLK) disable iff (RST)
    CE |=> LOG_EN == $past(rep_on))
    else $error("log enable level mismatch");
  a_fault_ce_none: assert property (@(posedge CLK) disable iff (RST)
    CE && rep_on && FEAT_CFI == ERC_FEAT_NONE && en_fi && ce_event |=> FAULT_IRQ)
    else $error("fault enable did not cover corrected event");
  a_ce_split_rd: assert property (@(posedge CLK) disable iff (RST)
    CE && rep_on && FEAT_CFI == ERC_FEAT_SPLIT && !EV_IS_WRITE && ctl_reg[ERC_READ_CORRECTED_FAULT_IRQ_EN_BIT]
    && ce_event |=> FAULT_IRQ)
    else $error("read corrected fault pulse missing");
  a_dui_write: assert property (@(posedge CLK) disable iff (RST)
    CE && rep_on && FEAT_DUI == ERC_FEAT_SPLIT && EV_IS_WRITE && ctl_reg[ERC_WRITE_DEFERRED_RECOVERY_IRQ_EN_BIT]
    && EV_DEFERRED |=> RECOVERY_IRQ)
    else $error("write deferred recovery pulse missing");
  a_dui_read: assert property (@(posedge CLK) disable iff (RST)
    CE && rep_on && FEAT_DUI == ERC_FEAT_SPLIT && !EV_IS_WRITE && ctl_reg[ERC_READ_DEFERRED_RECOVERY_IRQ_EN_BIT]
    && EV_DEFERRED |=> RECOVERY_IRQ)
    else $error("read deferred recovery pulse missing");
  a_ui_write: assert property (@(posedge CLK) disable iff (RST)
    CE && rep_on && FEAT_UI == ERC_FEAT_SPLIT && EV_IS_WRITE && ctl_reg[ERC_WUI_BIT]
    && EV_UNCORR |=> RECOVERY_IRQ)
    else $error("write uncorrected recovery pulse missing");
  a_ue_write: assert property (@(posedge CLK) disable iff (RST)
    CE && rep_on && FEAT_UE == ERC_FEAT_SPLIT && EV_IS_WRITE && ctl_reg[ERC_WUE_BIT]
    && EV_UNCORR |=> EXT_ABORT)
    else $error("write abort response missing");
  a_ue_read: assert property (@(posedge CLK) disable iff (RST)
    CE && rep_on && FEAT_UE == ERC_FEAT_SPLIT && !EV_IS_WRITE && ctl_reg[ERC_RUE_BIT]
    && EV_UNCORR |=> EXT_ABORT)
    else $error("read abort response missing");
  a_rdata_hold: assert property (@(posedge CLK) disable iff (RST)
    CE && !MM_RD |=> $stable(MM_RDATA))
    else $error("read data moved without a read");
  a_mm_view: assert property (@(posedge CLK) disable iff (RST)
    CE && MM_RD && mm_hit |=> MM_RDATA == $past(ctl_view))
    else $error("memory-mapped read data mismatch");
  a_sel_other: assert property (@(posedge CLK) disable iff (RST)
    CE && !sr_hit |=> SR_RDATA == 64'h0)
    else $error("unselected record window nonzero");
  a_hi_window: assert property (@(posedge CLK) disable iff (RST)
    CE && sr_hit && SR_WR_HI && !SR_WR_FULL |=> SR_RDATA[63:32] == 32'h0)
    else $error("high window view not right-aligned");
  a_full_view: assert property (@(posedge CLK) disable iff (RST)
    CE && sr_hit && !(SR_WR_HI && !SR_WR_FULL) |=> SR_RDATA == $past(ctl_view))
    else $error("full window view mismatch");
  a_impl_take: assert property (@(posedge CLK) disable iff (RST)
    CE && wr_hi |=> impl_hi_reg == $past(wdata[63:32]))
    else $error("implementation controls write not taken");
  a_ed_hold: assert property (@(posedge CLK) disable iff (RST)
    CE && !wr_lo |=> $stable(ed_reg))
    else $error("reporting enable moved without a write");
  // A low enable must leave every state bit and pulse where it was
  a_freeze_ctl: assert property (@(posedge CLK) disable iff (RST)
    !CE |=> $stable(ctl_reg) && $stable(ed_reg) && $stable(impl_hi_reg))
    else $error("control state moved while frozen");
  a_freeze_irq: assert property (@(posedge CLK) disable iff (RST)
    !CE |=> $stable(RECOVERY_IRQ) && $stable(FAULT_IRQ) && $stable(EXT_ABORT))
    else $error("event outputs moved while frozen");

endmodule

// ===== dv/error_record_control_test.sv
// Self-checking bench for the error record enable control register
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %s exp %h got %h", nm, exp, got); end end

module error_record_control_test;
  import erc_pkg::*;

  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 ce = 1'b1;
  logic                 mm_wr = 1'b0;
  logic                 mm_rd = 1'b0;
  logic [11:0]          mm_addr = 12'h000;
  logic [63:0]          mm_wdata = 64'h0;
  logic [63:0]          mm_rdata;
  logic [ERC_SEL_W-1:0] sel_idx = '0;
  logic                 sr_wr_lo = 1'b0;
  logic                 sr_wr_hi = 1'b0;
  logic                 sr_wr_full = 1'b0;
  logic [63:0]          sr_wdata = 64'h0;
  logic [63:0]          sr_rdata;
  logic [4:0]           evs = 5'h00;
  logic                 rec_irq;
  logic                 flt_irq;
  logic                 ext_abort;
  logic                 report_en;
  logic                 log_en;
  logic [63:0]          rd;
  int                   failures = 0;
  int                   checks = 0;

  always #5 clk = ~clk;

  erc_ctrl dut (
    .CLK(clk), .RST(rst), .CE(ce),
    .MM_WR(mm_wr), .MM_RD(mm_rd), .MM_ADDR(mm_addr), .MM_WDATA(mm_wdata),
    .MM_RDATA(mm_rdata), .SEL_IDX(sel_idx), .SR_WR_LO(sr_wr_lo), .SR_WR_HI(sr_wr_hi),
    .SR_WR_FULL(sr_wr_full), .SR_WDATA(sr_wdata), .SR_RDATA(sr_rdata),
    .EV_IS_WRITE(evs[4]), .EV_DEFERRED(evs[3]), .EV_UNCORR(evs[2]), .EV_CORR(evs[1]),
    .EV_CNT_OVF(evs[0]), .RECOVERY_IRQ(rec_irq), .FAULT_IRQ(flt_irq),
    .EXT_ABORT(ext_abort), .REPORT_EN(report_en), .LOG_EN(log_en)
  );

  // ---------------------------------------------------------------
  // Bus helpers
  // ---------------------------------------------------------------
  // Inputs always move 1 ns after the edge so no race with the sampling edge
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic mm_write(input logic [11:0] a, input logic [63:0] d);
    tick();
    mm_wr = 1'b1;
    mm_addr = a;
    mm_wdata = d;
    tick();
    mm_wr = 1'b0;
  endtask

  task automatic mm_read(input logic [11:0] a, output logic [63:0] d);
    tick();
    mm_rd = 1'b1;
    mm_addr = a;
    tick();
    mm_rd = 1'b0;
    d = mm_rdata;
  endtask

  // Window write: 0 low, 1 high, 2 full; then let the registered view settle
  task automatic sr_write(input int kind, input logic [63:0] d);
    tick();
    sr_wr_lo = (kind == 0);
    sr_wr_hi = (kind == 1);
    sr_wr_full = (kind == 2);
    sr_wdata = d;
    tick();
    {sr_wr_lo, sr_wr_hi, sr_wr_full} = 3'h0;
    tick();
    tick();
  endtask

  // Program the control, present one event, check {recovery, fault, abort}
  task automatic ev(input logic [11:0] ctl, input logic [4:0] e, input logic [2:0] exp);
    mm_write(ERC_CTL_BASE, {52'h0, ctl});
    tick();
    evs = e;
    tick();
    evs = 5'h00;
    `CHK("irqs", exp, {rec_irq, flt_irq, ext_abort})
    `CHK("report_en", ctl[0], report_en)
    `CHK("log_en", ctl[0], log_en)
    tick();
    `CHK("pulse_end", 3'h0, {rec_irq, flt_irq, ext_abort})
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    mm_read(ERC_CTL_BASE, rd);
    `CHK("ctl_reset", 64'h0, rd)
    `CHK("ed_reset", 1'b0, report_en)
  endtask

  // Every writable bit set: unused combined positions and 31:12 must stay zero
  task automatic t_layout();
    mm_write(ERC_CTL_BASE, 64'hffff_ffff_ffff_ffff);
    mm_read(ERC_CTL_BASE, rd);
    `CHK("ctl_layout", 64'hffff_ffff_0000_0dbf, rd)
    mm_write(ERC_CTL_BASE + ERC_REC_STRIDE, 64'hffff_ffff_ffff_ffff);
    mm_read(ERC_CTL_BASE + ERC_REC_STRIDE, rd);
    `CHK("rec1_raz", 64'h0, rd)
    mm_read(ERC_CTL_BASE, rd);
    `CHK("rec0_kept", 64'hffff_ffff_0000_0dbf, rd)
    mm_write(ERC_CTL_BASE, 64'h0000_0001_0000_0002);
    mm_read(ERC_CTL_BASE, rd);
    `CHK("impl_bits", 64'h0000_0001_0000_0002, rd)
  endtask

  task automatic t_windows();
    sel_idx = '0;
    sr_write(0, 64'h0000_0000_0000_0c01);
    sr_write(1, 64'h0000_0000_1234_5678);
    `CHK("sr_full_view", 64'h1234_5678_0000_0c01, sr_rdata)
    mm_read(ERC_CTL_BASE, rd);
    `CHK("mm_after_sr", 64'h1234_5678_0000_0c01, rd)
    sr_write(2, 64'h0000_00a0_0000_0095);
    `CHK("sr_full_wr", 64'h0000_00a0_0000_0095, sr_rdata)
    sel_idx = 2'h1;
    sr_write(2, 64'hffff_ffff_ffff_ffff);
    `CHK("sr_rec1_raz", 64'h0, sr_rdata)
    sel_idx = '0;
    mm_read(ERC_CTL_BASE, rd);
    `CHK("rec0_unhit", 64'h0000_00a0_0000_0095, rd)
  endtask

  // A write presented while the clock enable is low must be dropped
  task automatic t_freeze();
    ce = 1'b0;
    mm_write(ERC_CTL_BASE, 64'h0);
    ce = 1'b1;
    mm_read(ERC_CTL_BASE, rd);
    `CHK("ce_freeze", 64'h0000_00a0_0000_0095, rd)
  endtask

  // Event bits: {is_write, deferred, uncorrected, corrected, overflow}
  task automatic t_events();
    ev(12'h401, 5'b01000, 3'b100);
    ev(12'h401, 5'b11000, 3'b000);
    ev(12'h801, 5'b11000, 3'b100);
    ev(12'h400, 5'b01000, 3'b000);
    ev(12'h009, 5'b01000, 3'b010);
    ev(12'h009, 5'b10100, 3'b010);
    ev(12'h015, 5'b00100, 3'b101);
    ev(12'h015, 5'b01000, 3'b000);
    ev(12'h015, 5'b10100, 3'b000);
    ev(12'h0a1, 5'b10100, 3'b101);
    ev(12'h0a0, 5'b10100, 3'b000);
    ev(12'h101, 5'b10011, 3'b010);
    ev(12'h101, 5'b00010, 3'b000);
    ev(12'h009, 5'b00011, 3'b000);
  endtask

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  task automatic wrap_up();
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs only about 114 cycles
  initial begin
    #100000;
    failures++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_layout();
    t_windows();
    t_freeze();
    t_events();
    wrap_up();
  end
endmodule
